// ==== hdl/adcs_pkg.sv ====
// Package with register map, field layout, timing counts and shared types of the A/D sequencer
package adcs_pkg;

	// Clocking
	localparam int unsigned PCLK_HZ     = 200_000_000;
	localparam int unsigned E_CLK_HZ    = 2_000_000;
	localparam int unsigned E_DIV       = PCLK_HZ / E_CLK_HZ;
	localparam int unsigned E_DIV_W     = $clog2(E_DIV);

	// Per-channel resample period in continuous group scan, microseconds
	localparam int unsigned CH_PERIOD_US = 64;
	localparam int unsigned SEQ_E        = CH_PERIOD_US * (E_CLK_HZ / 1_000_000);
	localparam int unsigned CONV_E       = SEQ_E / 4;

	// Phases of one conversion, in E cycles
	localparam logic [4:0] SAMPLE_E  = 5'h0C;
	localparam logic [4:0] CMP_E     = 5'h10;
	localparam logic [4:0] CMP_END_E = SAMPLE_E + CMP_E;
	localparam logic [4:0] LAST_E    = 5'(CONV_E - 1);

	// Register indices as printed; byte address is four times the index
	localparam logic [15:0] IDX_CTL  = 16'h1030;
	localparam logic [15:0] IDX_RES1 = 16'h1031;
	localparam logic [15:0] IDX_RES2 = 16'h1032;
	localparam logic [15:0] IDX_RES3 = 16'h1033;
	localparam logic [15:0] IDX_RES4 = 16'h1034;
	localparam logic [15:0] IDX_OPT  = 16'h1039;
	localparam logic [15:0] ADDR_CTL  = {IDX_CTL[13:0], 2'h0};
	localparam logic [15:0] ADDR_RES1 = {IDX_RES1[13:0], 2'h0};
	localparam logic [15:0] ADDR_RES4 = {IDX_RES4[13:0], 2'h0};
	localparam logic [15:0] ADDR_OPT  = {IDX_OPT[13:0], 2'h0};

	// Control/status fields
	localparam int unsigned CTL_DONE  = 7;
	localparam int unsigned CTL_UNIMP = 6;
	localparam int unsigned CTL_SCAN  = 5;
	localparam int unsigned CTL_MULTI_CHANNEL_SELECT  = 4;
	localparam int unsigned OPT_PWR   = 7;
	localparam logic [5:0]  CTL_RESET = 6'h00;

	// Channel codes
	localparam logic [3:0] CH_EXT_LAST = 4'h7;
	localparam logic [3:0] CH_REF_HIGH = 4'hC;
	localparam logic [3:0] CH_REF_LOW  = 4'hD;
	localparam logic [3:0] CH_REF_HALF = 4'hE;
	localparam logic [3:0] CH_TEST     = 4'hF;

	localparam logic [7:0] SAR_FIRST = 8'h80;

	typedef struct packed {
		logic       scan;
		logic       multi_channel_select;
		logic [3:0] chan;
	} adcs_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_RUN,
		ST_SUSPEND
	} adcs_state_t;

endpackage

// ==== hdl/adcs_etick.sv ====
// E-clock tick generator dividing the bus clock
`timescale 1ns/10ps
module adcs_etick
	import adcs_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      e_tick
);

	logic [E_DIV_W-1:0] div_reg;
	logic [E_DIV_W-1:0] div_next;

	assign e_tick   = (div_reg == E_DIV_W'(E_DIV - 1));
	assign div_next = e_tick ? '0 : div_reg + E_DIV_W'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

endmodule

// ==== hdl/adcs_sar.sv ====
// Successive-approximation register, MSB first
`timescale 1ns/10ps
module adcs_sar
	import adcs_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic       step,
	input  wire logic       comp_above,
	output logic [7:0]      trial
);

	logic [7:0] trial_reg;
	logic [7:0] trial_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;

	// Keep the tested bit when the input is above the trial level, then try the next one
	always_comb begin
		trial_next = trial_reg;
		bit_next   = bit_reg;
		if (start) begin
			trial_next = SAR_FIRST;
			bit_next   = 3'h7;
		end else if (step) begin
			trial_next[bit_reg] = comp_above;
			if (bit_reg != 3'h0) begin
				trial_next[bit_reg - 3'h1] = 1'b1;
				bit_next = bit_reg - 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trial_reg <= 8'h00;
			bit_reg   <= 3'h0;
		end else begin
			trial_reg <= trial_next;
			bit_reg   <= bit_next;
		end
	end

	assign trial = trial_reg;

endmodule

// ==== hdl/adcs_top.sv ====
// A/D conversion sequencer with APB register slave
// What this block does
// [R01] Single channel one-shot: four results in order
// [R02] One-shot halts after fourth conversion
// [R03] Single channel scan keeps cycling result registers
// [R04] Group one-shot: each channel once, then halt
// [R05] Group scan repeats round-robin, overwriting results
// [R06] Low-power entry suspends; resume resamples channel
// [R07] Software waits 10 ms after undelayed stop exit
// [R08] Done flag read-only, bit 6 reads zero
// [R09] Write during sequence aborts and restarts it
// [R10] Done flag set on full set, write clears
// [R11] Scan sets done after first full sequence
// [R12] Single mode converts channel from bits 3:0
// [R13] Group mode: high bits pick group
// [R14] Channel codes: inputs, references, reserved codes
// [R15] Result registers read-only, writes ignored
// [R16] Results valid set only while done flag
// [R17] Group scan resamples each channel every 64 us
// [R18] Sequence starts within one E cycle after write
// [R19] Eight MSB-first comparisons, result copied out
// [R20] Converter runs only while power bit set
// [R21] No conversion before first control write
// [R22] Reserved codes run normal sequence timing
`timescale 1ns/10ps
module adcs_top
	import adcs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        low_power_req,
	input  wire logic        comp_above,
	output logic [3:0]       analog_chan,
	output logic             chan_reserved,
	output logic             sample_en,
	output logic [7:0]       dac_code,
	output logic             adc_enabled
);

	adcs_state_t state_reg;
	adcs_state_t state_next;
	adcs_ctl_t   ctl_reg;
	logic        done_reg;
	logic        pwr_reg;
	logic [7:0]  res_reg [4];
	logic [1:0]  idx_reg;
	logic [4:0]  ecnt_reg;
	logic [3:0]  chan_reg;
	logic        smp_reg;
	logic        lp_meta_reg;
	logic        lp_sync_reg;
	logic        cmp_meta_reg;
	logic        cmp_sync_reg;
	logic        e_tick;
	logic [7:0]  trial;

	// Bus decode
	wire acc      = psel && penable;
	wire hit_ctl  = (paddr == ADDR_CTL);
	wire hit_opt  = (paddr == ADDR_OPT);
	wire hit_res  = (paddr >= ADDR_RES1) && (paddr <= ADDR_RES4) && (paddr[1:0] == 2'h0);
	wire ctl_wr   = acc && pwrite && hit_ctl;
	wire opt_wr   = acc && pwrite && hit_opt;
	wire [1:0] res_sel = paddr[3:2] - ADDR_RES1[3:2];

	assign pready  = 1'b1;
	assign pslverr = acc && !(hit_ctl || hit_opt || hit_res);

	// Done flag read-only and bit 6 zero; result registers read-only
	wire [7:0] ctl_rd = {done_reg, 1'b0, ctl_reg.scan, ctl_reg.multi_channel_select, ctl_reg.chan}; // see [R08]
	assign prdata = hit_ctl ? {24'h0, ctl_rd} :
	                hit_opt ? {24'h0, pwr_reg, 7'h00} :
	                hit_res ? {24'h0, res_reg[res_sel]} : 32'h0; // see [R15]

	// Two-stage synchronisers for pin inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_meta_reg  <= 1'b0;
			lp_sync_reg  <= 1'b0;
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			lp_meta_reg  <= low_power_req;
			lp_sync_reg  <= lp_meta_reg;
			cmp_meta_reg <= comp_above;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	adcs_etick u_etick (
		.pclk    (pclk),
		.presetn (presetn),
		.e_tick  (e_tick)
	);

	// Conversion phase decode
	wire running    = (state_reg == ST_RUN);
	wire in_sample  = running && (ecnt_reg < SAMPLE_E);
	wire sar_start  = running && e_tick && (ecnt_reg == SAMPLE_E - 5'h1);
	wire sar_step   = running && e_tick && (ecnt_reg >= SAMPLE_E)
	                  && (ecnt_reg < CMP_END_E) && ecnt_reg[0]; // see [R19]
	wire store      = running && e_tick && (ecnt_reg == LAST_E) && !lp_sync_reg; // see [R17]
	wire last_store = store && (idx_reg == 2'h3);

	adcs_sar u_sar (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (sar_start),
		.step       (sar_step),
		.comp_above (cmp_sync_reg),
		.trial      (trial)
	);

	// Channel in single mode is the code; in group mode high bits plus position
	wire [3:0] chan_next = ctl_reg.multi_channel_select ? {ctl_reg.chan[3:2], idx_reg} : ctl_reg.chan; // see [R12] [R13]
	wire       chan_rsv  = (chan_reg > CH_EXT_LAST) && (chan_reg < CH_REF_HIGH)
	                       || (chan_reg == CH_TEST); // see [R14] [R22]

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				state_next = state_reg; // see [R21]
			end
			ST_ARM: begin
				if (e_tick && pwr_reg) begin
					state_next = ST_RUN; // see [R18]
				end
			end
			ST_RUN: begin
				if (!pwr_reg) begin
					state_next = ST_ARM; // see [R20]
				end else if (lp_sync_reg) begin
					state_next = ST_SUSPEND; // see [R06]
				end else if (last_store && !ctl_reg.scan) begin
					state_next = ST_IDLE; // see [R02] [R04]
				end
			end
			ST_SUSPEND: begin
				if (!pwr_reg) begin
					state_next = ST_ARM;
				end else if (!lp_sync_reg) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (ctl_wr) begin
			state_next = ST_ARM; // see [R09]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// E-cycle count within a conversion; suspension restarts sampling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ecnt_reg <= 5'h0;
		end else if (ctl_wr || state_reg != ST_RUN || lp_sync_reg) begin
			ecnt_reg <= 5'h0; // see [R06]
		end else if (e_tick) begin
			ecnt_reg <= (ecnt_reg == LAST_E) ? 5'h0 : ecnt_reg + 5'h1;
		end
	end

	// Result position wraps so later conversions overwrite in order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_reg <= 2'h0;
		end else if (ctl_wr || state_reg == ST_ARM) begin
			idx_reg <= 2'h0;
		end else if (store) begin
			idx_reg <= idx_reg + 2'h1; // see [R01] [R03] [R05]
		end
	end

	// Result storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				res_reg[i] <= 8'h00;
			end
		end else if (store && !ctl_wr) begin
			res_reg[idx_reg] <= trial; // see [R19]
		end
	end

	// Control, power and done flag; a write clears the flag and aborts the store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg  <= adcs_ctl_t'(CTL_RESET);
			pwr_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			if (ctl_wr) begin
				ctl_reg <= adcs_ctl_t'(pwdata[5:0]);
			end
			if (opt_wr) begin
				pwr_reg <= pwdata[OPT_PWR];
			end
			if (ctl_wr) begin
				done_reg <= 1'b0; // see [R10]
			end else if (last_store) begin
				done_reg <= 1'b1; // see [R10] [R11]
			end
		end
	end

	// Analog-side outputs registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_reg <= 4'h0;
			smp_reg  <= 1'b0;
		end else begin
			chan_reg <= chan_next;
			smp_reg  <= in_sample && !lp_sync_reg;
		end
	end

	assign analog_chan   = chan_reg;
	assign chan_reserved = chan_rsv;
	assign sample_en     = smp_reg;
	assign dac_code      = trial;
	assign adc_enabled   = pwr_reg; // see [R20]

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ctl_write;
		ctl_wr;
	endsequence

	sequence s_last_store;
		last_store && !ctl_wr && pwr_reg && !lp_sync_reg;
	endsequence

	chk_done_clear: assert property (s_ctl_write |=> !done_reg) // see [R10]
		else $error("done flag not cleared by control write");
	chk_start_delay: assert property (s_ctl_write and (pwr_reg && !opt_wr)
		|=> state_reg == ST_ARM ##[1:100] running) // see [R18]
		else $error("sequence did not start within one E cycle");
	chk_oneshot_halt: assert property (s_last_store and !ctl_reg.scan |=> state_reg == ST_IDLE) // see [R02]
		else $error("one-shot sequence did not halt");
	chk_scan_wrap: assert property (s_last_store and ctl_reg.scan
		|=> running && idx_reg == 2'h0 && done_reg) // see [R11]
		else $error("scan did not wrap with done flag set");
	chk_bit6_zero: assert property (psel && hit_ctl |-> prdata[CTL_UNIMP] == 1'b0) // see [R08]
		else $error("unimplemented bit reads nonzero");
	chk_result_store: assert property (store && !ctl_wr |=> res_reg[$past(idx_reg)] == $past(trial)) // see [R19]
		else $error("result not copied to its register");
	chk_group_chan: assert property (running && ctl_reg.multi_channel_select
		|=> chan_reg == {$past(ctl_reg.chan[3:2]), $past(idx_reg)}) // see [R13]
		else $error("group channel mapping wrong");
	chk_suspend_entry: assert property (running && lp_sync_reg && pwr_reg && !ctl_wr |=> state_reg == ST_SUSPEND && ecnt_reg == 5'h0) // see [R06]
		else $error("low-power entry did not suspend");
	chk_power_gate: assert property (!pwr_reg |=> !running) // see [R20]
		else $error("converter ran while powered down");

	// Storage, flag hold and sample gating
	sequence s_result_write;
		acc && pwrite && hit_res;
	endsequence

	sequence s_flag_kept;
		done_reg && !ctl_wr;
	endsequence

	// A bus write to a result slot leaves it untouched
	chk_result_ro: assert property (s_result_write and !store
		|=> res_reg[$past(res_sel)] == $past(res_reg[res_sel])) // see [R15]
		else $error("result register changed by bus write");

	// Flag stays up until software writes the control register
	chk_flag_hold: assert property (s_flag_kept |=> done_reg) // see [R10]
		else $error("done flag dropped without control write");

	// Fourth store of a sequence raises the flag
	chk_flag_set: assert property (s_last_store |=> done_reg) // see [R10] [R11]
		else $error("done flag not set after fourth store");

	// No sampling unless a sequence runs
	chk_sample_gate: assert property (!running |=> !sample_en) // see [R20] [R21]
		else $error("sample phase outside a running sequence");

	// Idle holds until a control write
	chk_idle_hold: assert property (state_reg == ST_IDLE && !ctl_wr |=> state_reg == ST_IDLE) // see [R21]
		else $error("sequencer left idle without control write");

	// Every conversion starts from the top bit
	chk_sar_start: assert property (sar_start |=> trial == SAR_FIRST) // see [R19]
		else $error("approximation did not start at top bit");

endmodule

// ==== verif/adcs_analog_model.sv ====
// Behavioural model of the multiplexed analog inputs and the comparator
`timescale 1ns/10ps
module adcs_analog_model (
	input  wire logic [3:0] analog_chan,
	input  wire logic       pclk,
	input  wire logic       sample_en,
	input  wire logic [7:0] dac_code,
	output logic            comp_above
);
	logic [7:0] held;
	initial held = 8'h00;
	// Each channel sits at its own level; the level is held after sampling
	always @(posedge pclk) begin
		if (sample_en) begin
			held <= {analog_chan, ~analog_chan};
		end
	end
	assign comp_above = (held >= dac_code);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking testbench of the A/D sequencer
`timescale 1ns/10ps
module tb_top;
	import adcs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, low_power_req, er;
	logic        pready, pslverr, comp_above, chan_reserved, sample_en, adc_enabled;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  analog_chan;
	logic [7:0]  dac_code;
	int          failures, comparisons, n;
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;
	adcs_top dut (
		.pclk          (pclk),
		.presetn       (presetn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.low_power_req (low_power_req),
		.comp_above    (comp_above),
		.analog_chan   (analog_chan),
		.chan_reserved (chan_reserved),
		.sample_en     (sample_en),
		.dac_code      (dac_code),
		.adc_enabled   (adc_enabled)
	);
	adcs_analog_model model (
		.analog_chan (analog_chan),
		.pclk        (pclk),
		.sample_en   (sample_en),
		.dac_code    (dac_code),
		.comp_above  (comp_above)
	);
	task automatic test_done;
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	task automatic fail_out(input string nm);
		$display("Error %s expected completion seen timeout", nm);
		failures++;
		test_done;
	endtask
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) fail_out("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_done;
		int k;
		k = 0;
		do begin
			xfer(1'b0, ADDR_CTL, 32'h0);
			k++;
		end while (rd[CTL_DONE] !== 1'b1 && k < 6000);
		if (k >= 6000) fail_out("done flag");
	endtask
	task automatic chk_res(input logic [3:0] c0, input logic grp);
		logic [3:0] c;
		for (int i = 0; i < 4; i++) begin
			c = grp ? c0 + 4'(i) : c0;
			xfer(1'b0, ADDR_RES1 + 16'(4 * i), 32'h0);
			chk("result", {24'h0, c, ~c}, rd);
		end
	endtask
	// Cycles until sample_en next rises; when chan0 is set only channel 0 counts
	task automatic rise(input logic chan0, output int k);
		logic lo;
		k = 0;
		lo = 1'b0;
		do begin
			@(posedge pclk);
			k++;
			if (sample_en !== 1'b1) lo = 1'b1;
		end while (!(lo && sample_en === 1'b1 && (!chan0 || analog_chan === 4'h0)) && k < 20000);
		if (k >= 20000) fail_out("sample start");
	endtask
	task automatic count_se(input int c, output int k);
		k = 0;
		repeat (c) begin
			@(posedge pclk);
			if (sample_en !== 1'b0) k++;
		end
	endtask
	task automatic t_reset;
		chk("idle sample", 32'h0, {31'h0, sample_en});
		xfer(1'b0, ADDR_CTL, 32'h0);
		chk("ctl reset", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, ADDR_RES1 + 16'(4 * i), 32'h0);
			chk("result reset", 32'h0, rd);
		end
		xfer(1'b0, 16'h0000, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		xfer(1'b1, ADDR_OPT, 32'h80);
		@(negedge pclk);
		chk("power on", 32'h1, {31'h0, adc_enabled});
		$display("test reset done");
	endtask
	task automatic t_single;
		xfer(1'b1, ADDR_CTL, 32'h03);
		rise(1'b0, n);
		chk("start delay", 32'h1, {31'h0, n <= 105});
		wait_done;
		chk("ctl done", 32'h83, rd);
		chk_res(4'h3, 1'b0);
		xfer(1'b1, ADDR_RES1, 32'hFF);
		chk("result write err", 32'h0, {31'h0, er});
		chk_res(4'h3, 1'b0);
		count_se(3300, n);
		chk("halted", 32'h0, n);
		$display("test single done");
	endtask
	task automatic t_group;
		xfer(1'b1, ADDR_CTL, 32'hD7);
		xfer(1'b0, ADDR_CTL, 32'h0);
		chk("ctl readback", 32'h17, rd);
		wait_done;
		chk("ctl done", 32'h97, rd);
		chk_res(4'h4, 1'b1);
		$display("test group done");
	endtask
	task automatic t_abort_scan;
		xfer(1'b1, ADDR_CTL, 32'h22);
		repeat (2000) @(posedge pclk);
		xfer(1'b1, ADDR_CTL, 32'h30);
		wait_done;
		chk_res(4'h0, 1'b1);
		rise(1'b1, n);
		rise(1'b1, n);
		chk("resample gap", 32'd12800, n);
		$display("test abort scan done");
	endtask
	task automatic t_codes;
		logic [3:0] cd [4] = '{4'h8, 4'hB, 4'hC, 4'hF};
		logic       rs [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, ADDR_CTL, {28'h0, cd[i]});
			rise(1'b0, n);
			chk("channel", {28'h0, cd[i]}, {28'h0, analog_chan});
			chk("reserved", {31'h0, rs[i]}, {31'h0, chan_reserved});
		end
		$display("test codes done");
	endtask
	task automatic t_suspend;
		xfer(1'b1, ADDR_CTL, 32'h01);
		repeat (1000) @(posedge pclk);
		low_power_req <= 1'b1;
		count_se(500, n);
		chk("suspended", 32'h0, {31'h0, sample_en});
		low_power_req <= 1'b0;  // wait-mode exit, no settle time needed
		rise(1'b0, n);
		chk("resample", 32'h1, {31'h0, n <= 10});
		wait_done;
		chk_res(4'h1, 1'b0);
		xfer(1'b1, ADDR_OPT, 32'h00);
		@(negedge pclk);
		chk("power off", 32'h0, {31'h0, adc_enabled});
		xfer(1'b1, ADDR_CTL, 32'h02);
		count_se(2000, n);
		chk("unpowered", 32'h0, n);
		$display("test suspend done");
	endtask
	initial begin
		failures = 0;
		comparisons = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		low_power_req = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_single;
		t_group;
		t_abort_scan;
		t_codes;
		t_suspend;
		test_done;
	end
endmodule
